// [asc_pkg.sv]
// Register map, field layout, reset values and timing constants of the ADC sequencer
package asc_pkg;
	localparam logic [31:0] BASE_OFF = 32'h5000_1500;
	localparam logic [31:0] OFF_MAIN = 32'h5000_1500;
	localparam logic [31:0] OFF_TIMING = 32'h5000_1502;
	localparam logic [31:0] OFF_INTERVAL = 32'h5000_1504;
	localparam logic [31:0] OFF_SELECT = 32'h5000_1506;
	localparam logic [31:0] OFF_POS_OFS = 32'h5000_1508;
	localparam logic [31:0] OFF_NEG_OFS = 32'h5000_150A;
	localparam logic [31:0] OFF_TRIM = 32'h5000_150C;
	localparam logic [31:0] OFF_IRQ_CLR = 32'h5000_150E;
	localparam logic [31:0] OFF_RESULT = 32'h5000_1510;
	localparam int B_ON = 0;
	localparam int B_START = 1;
	localparam int B_CONT = 2;
	localparam int B_DMA = 3;
	localparam int B_FLAG = 4;
	localparam int B_MASK = 5;
	localparam int B_SE = 6;
	localparam int B_MUTE = 7;
	localparam int B_SIGN = 8;
	localparam int B_CHOP = 9;
	localparam int B_HOLD = 10;
	localparam int B_TEMP = 12;
	localparam logic [15:0] MAIN_RW_MASK = 16'h17ED;
	localparam logic [15:0] MAIN_RST = 16'h0000;
	localparam logic [15:0] TIMING_RST = 16'h0210;
	localparam logic [15:0] INTERVAL_RST = 16'h0040;
	localparam logic [7:0] SELECT_MASK = 8'h77;
	localparam logic [7:0] SELECT_RST = 8'h00;
	localparam logic [9:0] OFS_RST = 10'h200;
	localparam logic [6:0] TRIM_RST = 7'h38;
	localparam int CLK_PERIOD_NS = 50;
	localparam int GAP_STEP_NS = 1024000;
	localparam int GAP_STEP_CYC = (GAP_STEP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam logic [6:0] SAMPLE_MIN_CYC = 7'h02;
	localparam logic [6:0] SAMPLE_STEP_CYC = 7'h08;
	localparam logic [9:0] ENDEL_STEP_CYC = 10'h004;
	localparam logic [3:0] STORE_SHORT_CYC = 4'h2;
	localparam logic [3:0] STORE_LONG_CYC = 4'h8;
	localparam logic [2:0] FULL_EXTRA_BITS = 3'h6;

	typedef enum logic [2:0] {
		ST_OFF = 3'h0,
		ST_PWRUP = 3'h1,
		ST_IDLE = 3'h2,
		ST_SAMPLE = 3'h3,
		ST_CONVERT = 3'h4,
		ST_STORE = 3'h5,
		ST_GAP = 3'h6
	} asc_state_t;

	function automatic logic [7:0] asc_addr(input logic [31:0] off);
		logic [31:0] d;
		d = (off - BASE_OFF) << 2;
		return d[7:0];
	endfunction : asc_addr
endpackage : asc_pkg

// [asc_sequencer.sv]
// ADC sequencer control: APB register bank, power-up, sampling and result storage
// Operation
// - Enable powers regulator first, then converter
// - Writing start bit launches conversion
// - Completion sets ready flag; in single mode it also clears start
// - Ready flag held until clear register written
// - Mask bit gates ready interrupt out
// - Single gives one result, continuous repeats
// - Interval adds 1.024 ms per step
// - Input mode selects differential or single-ended
// - Chopper takes opposite-polarity sample pairs
// - Polarity bit inverts converter sign
// - Mute samples mid-scale, input disconnected
// - Hold bit selects tracked or sampled reference
// - Temperature sensor enable, read on input 4
// - Store delay selects result latch moment
// - Sample time two cycles or value times eight
// - Average two-to-the-field samples, chop minimum two
// - Shifter common mode select, reset one
// - Input shifter moves upper range down
// - Load current bit adds regulator load
// - Attenuator select; software lengthens sample time
// - Result left-aligned in sixteen bits
//
// The APB interface to the registers was decided locally.
`timescale 1ns/100ps
`default_nettype none
module asc_sequencer #(
	parameter int GAP_STEP_CYCLES = asc_pkg::GAP_STEP_CYC
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic [31:0] paddr,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic sample_valid,
	input wire logic [9:0] sample_data,
	output logic regulator_on,
	output logic converter_enable,
	output logic sample_close,
	output logic convert_go,
	output logic polarity_invert,
	output logic chopper_on,
	output logic single_ended_sel,
	output logic input_mute,
	output logic regulator_hold,
	output logic die_temp_on,
	output logic shifter_on,
	output logic [1:0] shifter_common_mode,
	output logic load_current_on,
	output logic [1:0] attenuator_sel,
	output logic [2:0] input_pos_sel,
	output logic [2:0] input_neg_sel,
	output logic [9:0] pos_offset,
	output logic [9:0] neg_offset,
	output logic [6:0] trim_value,
	output logic ready_irq,
	output logic dma_request
);
	localparam logic [7:0] A_MAIN = asc_pkg::asc_addr(asc_pkg::OFF_MAIN);
	localparam logic [7:0] A_TIMING = asc_pkg::asc_addr(asc_pkg::OFF_TIMING);
	localparam logic [7:0] A_INTERVAL = asc_pkg::asc_addr(asc_pkg::OFF_INTERVAL);
	localparam logic [7:0] A_SELECT = asc_pkg::asc_addr(asc_pkg::OFF_SELECT);
	localparam logic [7:0] A_POS_OFS = asc_pkg::asc_addr(asc_pkg::OFF_POS_OFS);
	localparam logic [7:0] A_NEG_OFS = asc_pkg::asc_addr(asc_pkg::OFF_NEG_OFS);
	localparam logic [7:0] A_TRIM = asc_pkg::asc_addr(asc_pkg::OFF_TRIM);
	localparam logic [7:0] A_IRQ_CLR = asc_pkg::asc_addr(asc_pkg::OFF_IRQ_CLR);
	localparam logic [7:0] A_RESULT = asc_pkg::asc_addr(asc_pkg::OFF_RESULT);

	typedef struct packed {
		asc_pkg::asc_state_t st;
		logic [15:0] main;
		logic start;
		logic flag;
		logic [15:0] timing;
		logic [15:0] interval;
		logic [7:0] select;
		logic [9:0] pos_ofs;
		logic [9:0] neg_ofs;
		logic [6:0] trim;
		logic [15:0] result;
		logic [23:0] cnt;
		logic [9:0] pcnt;
		logic [7:0] left;
		logic [16:0] acc;
		logic phase;
		logic reg_on;
		logic adc_en;
		logic close;
		logic go;
		logic pol;
		logic irq;
		logic dma;
		logic pready;
		logic pslverr;
		logic [31:0] prdata;
	} asc_regs_t;

	localparam asc_regs_t RST = '{
		st: asc_pkg::ST_OFF,
		main: asc_pkg::MAIN_RST,
		timing: asc_pkg::TIMING_RST,
		interval: asc_pkg::INTERVAL_RST,
		select: asc_pkg::SELECT_RST,
		pos_ofs: asc_pkg::OFS_RST,
		neg_ofs: asc_pkg::OFS_RST,
		trim: asc_pkg::TRIM_RST,
		default: '0
	};

	asc_regs_t s_reg;
	asc_regs_t s_next;
	logic clr_hit;
	logic store_done;

	// Sampling switch closure length in converter clocks
	function automatic logic [23:0] sample_cycles(input logic [3:0] sel);
		logic [6:0] c;
		c = (sel == 4'h0) ? asc_pkg::SAMPLE_MIN_CYC : 7'(sel * asc_pkg::SAMPLE_STEP_CYC);
		return {17'h0, c};
	endfunction : sample_cycles

	// Extra resolution bits gained by averaging; chopping never goes below one pair
	function automatic logic [2:0] extra_bits(input logic [2:0] nrs, input logic chop);
		return (nrs == 3'h0 && chop) ? 3'h1 : nrs;
	endfunction : extra_bits

	// Left-align the sum; beyond six extra bits the lowest bit has no room and is dropped
	function automatic logic [15:0] align(input logic [16:0] sum, input logic [2:0] e);
		logic [16:0] sh;
		if (e <= asc_pkg::FULL_EXTRA_BITS) begin
			sh = sum << (asc_pkg::FULL_EXTRA_BITS - e);
			return sh[15:0];
		end
		return sum[16:1];
	endfunction : align

	function automatic logic [23:0] store_cycles(input logic [2:0] sel);
		case (sel)
			3'h1: return {20'h0, asc_pkg::STORE_SHORT_CYC};
			3'h2: return {20'h0, asc_pkg::STORE_LONG_CYC};
			default: return 24'h000001;
		endcase
	endfunction : store_cycles

	always_comb begin
		logic acc_phase;
		logic [7:0] a;
		logic [15:0] rdv;
		logic flag_set;
		logic [2:0] e;
		logic begin_conv;
		acc_phase = psel && penable && !s_reg.pready;
		a = paddr[7:0];
		rdv = 16'h0000;
		flag_set = 1'b0;
		begin_conv = 1'b0;
		clr_hit = 1'b0;
		store_done = 1'b0;
		s_next = s_reg;
		s_next.pready = 1'b0;
		s_next.pslverr = 1'b0;
		s_next.go = 1'b0;
		s_next.dma = 1'b0;
		e = extra_bits(s_reg.timing[8:6], s_reg.main[asc_pkg::B_CHOP]);

		if (acc_phase) begin
			s_next.pready = 1'b1;
			s_next.prdata = 32'h0000_0000;
			case (a)
				A_MAIN: begin
					rdv = s_reg.main;
					rdv[asc_pkg::B_START] = s_reg.start;
					rdv[asc_pkg::B_FLAG] = s_reg.flag;
					if (pwrite) begin
						s_next.main = pwdata[15:0] & asc_pkg::MAIN_RW_MASK;
						if (pwdata[asc_pkg::B_START]) begin
							// Only a 1 acts; busy rewrites are left to software discipline
							s_next.start = 1'b1;
						end
					end
				end
				A_TIMING: begin
					rdv = s_reg.timing;
					if (pwrite) begin
						s_next.timing = pwdata[15:0];
					end
				end
				A_INTERVAL: begin
					rdv = s_reg.interval;
					if (pwrite) begin
						s_next.interval = pwdata[15:0];
					end
				end
				A_SELECT: begin
					rdv = {8'h00, s_reg.select};
					if (pwrite) begin
						s_next.select = pwdata[7:0] & asc_pkg::SELECT_MASK;
					end
				end
				A_POS_OFS: begin
					rdv = {6'h00, s_reg.pos_ofs};
					if (pwrite) begin
						s_next.pos_ofs = pwdata[9:0];
					end
				end
				A_NEG_OFS: begin
					rdv = {6'h00, s_reg.neg_ofs};
					if (pwrite) begin
						s_next.neg_ofs = pwdata[9:0];
					end
				end
				A_TRIM: begin
					rdv = {9'h000, s_reg.trim};
					if (pwrite) begin
						s_next.trim = pwdata[6:0];
					end
				end
				A_IRQ_CLR: begin
					clr_hit = pwrite;
				end
				A_RESULT: begin
					rdv = s_reg.result;
				end
				default: begin
					s_next.pslverr = 1'b1;
				end
			endcase
			if (!pwrite) begin
				s_next.prdata = {16'h0000, rdv};
			end
		end

		case (s_reg.st)
			asc_pkg::ST_OFF: begin
				if (s_reg.main[asc_pkg::B_ON]) begin
					s_next.reg_on = 1'b1;
					s_next.pcnt = (s_reg.interval[7:0] == 8'h00) ? asc_pkg::ENDEL_STEP_CYC :
						10'(s_reg.interval[7:0] * asc_pkg::ENDEL_STEP_CYC);
					s_next.st = asc_pkg::ST_PWRUP;
				end
			end
			asc_pkg::ST_PWRUP: begin
				s_next.pcnt = s_reg.pcnt - 10'h001;
				if (s_reg.pcnt <= 10'h001) begin
					s_next.adc_en = 1'b1;
					s_next.st = asc_pkg::ST_IDLE;
				end
			end
			asc_pkg::ST_IDLE: begin
				begin_conv = s_reg.start;
			end
			asc_pkg::ST_SAMPLE: begin
				s_next.cnt = s_reg.cnt - 24'h000001;
				if (s_reg.cnt <= 24'h000001) begin
					s_next.close = 1'b0;
					s_next.go = 1'b1;
					s_next.st = asc_pkg::ST_CONVERT;
				end
			end
			asc_pkg::ST_CONVERT: begin
				if (sample_valid) begin
					s_next.acc = s_reg.acc + {7'h00, sample_data};
					s_next.left = s_reg.left - 8'h01;
					if (s_reg.main[asc_pkg::B_CHOP]) begin
						s_next.phase = !s_reg.phase;
					end
					if (s_reg.left <= 8'h01) begin
						s_next.cnt = store_cycles(s_reg.timing[15:13]);
						s_next.st = asc_pkg::ST_STORE;
					end else begin
						s_next.cnt = sample_cycles(s_reg.timing[12:9]);
						s_next.close = 1'b1;
						s_next.st = asc_pkg::ST_SAMPLE;
					end
				end
			end
			asc_pkg::ST_STORE: begin
				s_next.cnt = s_reg.cnt - 24'h000001;
				if (s_reg.cnt <= 24'h000001) begin
					store_done = 1'b1;
					s_next.result = align(s_reg.acc, e);
					flag_set = 1'b1;
					s_next.dma = s_reg.main[asc_pkg::B_DMA];
					if (s_reg.main[asc_pkg::B_CONT]) begin
						if (s_reg.interval[15:8] == 8'h00) begin
							begin_conv = 1'b1;
						end else begin
							s_next.cnt = 24'(s_reg.interval[15:8] * GAP_STEP_CYCLES);
							s_next.st = asc_pkg::ST_GAP;
						end
					end else begin
						s_next.start = 1'b0;
						s_next.st = asc_pkg::ST_IDLE;
					end
				end
			end
			asc_pkg::ST_GAP: begin
				s_next.cnt = s_reg.cnt - 24'h000001;
				if (!s_reg.main[asc_pkg::B_CONT]) begin
					s_next.start = 1'b0;
					s_next.st = asc_pkg::ST_IDLE;
				end else if (s_reg.cnt <= 24'h000001) begin
					begin_conv = 1'b1;
				end
			end
			default: begin
				s_next.st = asc_pkg::ST_OFF;
			end
		endcase

		if (begin_conv) begin
			s_next.acc = 17'h00000;
			s_next.left = 8'(9'h001 << e);
			s_next.phase = 1'b0;
			s_next.cnt = sample_cycles(s_reg.timing[12:9]);
			s_next.close = 1'b1;
			s_next.st = asc_pkg::ST_SAMPLE;
		end

		// Disabling drops regulator, converter and sampling at once; a running conversion is abandoned, the ready flag kept
		if (!s_reg.main[asc_pkg::B_ON]) begin
			s_next.reg_on = 1'b0;
			s_next.adc_en = 1'b0;
			s_next.close = 1'b0;
			s_next.go = 1'b0;
			s_next.start = 1'b0;
			s_next.st = asc_pkg::ST_OFF;
			if (acc_phase && pwrite && a == A_MAIN && pwdata[asc_pkg::B_START]) begin
				s_next.start = 1'b1;
			end
		end

		// A completion in the clearing cycle keeps the flag set
		s_next.flag = flag_set || (s_reg.flag && !clr_hit);
		s_next.irq = s_next.flag && s_next.main[asc_pkg::B_MASK];
		s_next.pol = s_next.main[asc_pkg::B_SIGN] ^ s_next.phase;
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			s_reg <= RST;
		end else begin
			s_reg <= s_next;
		end
	end

	assign prdata = s_reg.prdata;
	assign pready = s_reg.pready;
	assign pslverr = s_reg.pslverr;
	assign regulator_on = s_reg.reg_on;
	assign converter_enable = s_reg.adc_en;
	assign sample_close = s_reg.close;
	assign convert_go = s_reg.go;
	assign polarity_invert = s_reg.pol;
	assign chopper_on = s_reg.main[asc_pkg::B_CHOP];
	assign single_ended_sel = s_reg.main[asc_pkg::B_SE];
	assign input_mute = s_reg.main[asc_pkg::B_MUTE];
	assign regulator_hold = s_reg.main[asc_pkg::B_HOLD];
	assign die_temp_on = s_reg.main[asc_pkg::B_TEMP];
	assign shifter_on = s_reg.timing[3];
	assign shifter_common_mode = s_reg.timing[5:4];
	assign load_current_on = s_reg.timing[2];
	assign attenuator_sel = s_reg.timing[1:0];
	assign input_pos_sel = s_reg.select[6:4];
	assign input_neg_sel = s_reg.select[2:0];
	assign pos_offset = s_reg.pos_ofs;
	assign neg_offset = s_reg.neg_ofs;
	assign trim_value = s_reg.trim;
	assign ready_irq = s_reg.irq;
	assign dma_request = s_reg.dma;

	reg_order_a: assert property (@(posedge pclk) disable iff (!presetn)
		$rose(s_reg.adc_en) |-> $past(s_reg.reg_on))
		else $error("converter enabled before regulator");
	power_off_a: assert property (@(posedge pclk) disable iff (!presetn)
		!s_reg.main[asc_pkg::B_ON] |=> !s_reg.reg_on && !s_reg.adc_en)
		else $error("regulator or converter left on");
	start_launch_a: assert property (@(posedge pclk) disable iff (!presetn)
		psel && penable && !s_reg.pready && pwrite && paddr[7:0] == A_MAIN &&
		pwdata[asc_pkg::B_START] && pwdata[asc_pkg::B_ON] && s_reg.st == asc_pkg::ST_IDLE
		|=> s_reg.start ##1 s_reg.close)
		else $error("start write did not launch sampling");
	done_clear_a: assert property (@(posedge pclk) disable iff (!presetn)
		store_done && !s_reg.main[asc_pkg::B_CONT] && s_reg.main[asc_pkg::B_ON]
		|=> !s_reg.start && s_reg.flag && s_reg.st == asc_pkg::ST_IDLE)
		else $error("completion did not clear start and set flag");
	flag_hold_a: assert property (@(posedge pclk) disable iff (!presetn)
		$fell(s_reg.flag) |-> $past(clr_hit))
		else $error("ready flag fell without clear write");
	irq_mask_a: assert property (@(posedge pclk) disable iff (!presetn)
		$rose(s_reg.flag) |-> ready_irq == s_reg.main[asc_pkg::B_MASK])
		else $error("interrupt not gated by mask");
	sample_len_a: assert property (@(posedge pclk) disable iff (!presetn)
		$rose(s_reg.close) && s_reg.timing[12:9] == 4'h1 && s_reg.main[asc_pkg::B_ON]
		&& $stable(s_reg.main) |-> s_reg.close[*8] ##1 !s_reg.close)
		else $error("sample closure length wrong");
	gap_entry_a: assert property (@(posedge pclk) disable iff (!presetn)
		store_done && s_reg.main[asc_pkg::B_CONT] && s_reg.main[asc_pkg::B_ON] &&
		s_reg.interval[15:8] != 8'h00 |=> s_reg.st == asc_pkg::ST_GAP)
		else $error("continuous gap not inserted");
	unused_zero_a: assert property (@(posedge pclk) disable iff (!presetn)
		$rose(s_reg.pready) && $past(paddr[7:0]) == A_MAIN && !$past(pwrite)
		|-> prdata[11] == 1'b0 && prdata[15:13] == 3'h0)
		else $error("unused main control bits not zero");
endmodule : asc_sequencer
`default_nettype wire

// [asc_sequencer_tb.sv]
// Self-checking testbench for the ADC sequencer control block
`timescale 1ns/100ps
`default_nettype none
module asc_sequencer_tb;
	localparam logic [31:0] A_MAIN = 32'h00;
	localparam logic [31:0] A_TIM = 32'h08;
	localparam logic [31:0] A_INT = 32'h10;
	localparam logic [31:0] A_SEL = 32'h18;
	localparam logic [31:0] A_CLR = 32'h38;
	localparam logic [31:0] A_RES = 32'h40;
	logic pclk, presetn, psel, penable, pwrite, pready, pslverr, sample_valid, errv;
	logic [31:0] paddr, pwdata, prdata, rdv;
	logic [9:0] sample_data, resp, pos_offset, neg_offset;
	logic regulator_on, converter_enable, sample_close, convert_go, polarity_invert, chopper_on;
	logic single_ended_sel, input_mute, regulator_hold, die_temp_on, shifter_on;
	logic load_current_on, ready_irq, dma_request;
	logic [1:0] shifter_common_mode, attenuator_sel, pol_log;
	logic [2:0] input_pos_sel, input_neg_sel;
	logic [6:0] trim_value;
	logic [31:0] ra [9] = '{32'h00, 32'h08, 32'h10, 32'h18, 32'h20, 32'h28, 32'h30, 32'h38, 32'h40};
	logic [31:0] re [9] = '{32'h0, 32'h210, 32'h40, 32'h0, 32'h200, 32'h200, 32'h38, 32'h0, 32'h0};
	int mismatches, checks_done, cycles, go_cnt, close_cnt;

	asc_sequencer #(.GAP_STEP_CYCLES(4)) u_dut (.pclk(pclk), .presetn(presetn), .paddr(paddr),
		.psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .sample_valid(sample_valid),
		.sample_data(sample_data), .regulator_on(regulator_on),
		.converter_enable(converter_enable), .sample_close(sample_close),
		.convert_go(convert_go),
		.polarity_invert(polarity_invert), .chopper_on(chopper_on),
		.single_ended_sel(single_ended_sel), .input_mute(input_mute),
		.regulator_hold(regulator_hold), .die_temp_on(die_temp_on), .shifter_on(shifter_on),
		.shifter_common_mode(shifter_common_mode), .load_current_on(load_current_on),
		.attenuator_sel(attenuator_sel), .input_pos_sel(input_pos_sel),
		.input_neg_sel(input_neg_sel), .pos_offset(pos_offset), .neg_offset(neg_offset),
		.trim_value(trim_value), .ready_irq(ready_irq), .dma_request(dma_request));

	initial begin
		pclk = 1'b0;
		forever #25 pclk = ~pclk;
	end

	task automatic wrap_up();
		$display("checks_done=%0d mismatches=%0d", checks_done, mismatches);
		if (mismatches == 0 && checks_done > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask : wrap_up

	// Converter stand-in answers every conversion one cycle after its go pulse
	always @(posedge pclk) begin
		sample_valid <= convert_go;
		sample_data <= resp;
		if (convert_go === 1'b1) begin
			pol_log <= {pol_log[0], polarity_invert};
			go_cnt <= go_cnt + 1;
		end
		// Counted only while closed, so a bench reset of the count is never overwritten
		if (sample_close === 1'b1) begin
			close_cnt <= close_cnt + 1;
		end
		cycles++;
		if (cycles == 20000) begin
			mismatches++;
			wrap_up();
		end
	end

	task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		checks_done++;
		if (seen !== exp) begin
			mismatches++;
			$display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
		end
	endtask : check

	// Request held until pready is sampled high; no cycle count assumed
	task automatic apb(input logic wr, input logic [31:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do begin
			@(posedge pclk);
		end while (pready !== 1'b1);
		rdv = prdata;
		errv = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb

	task automatic rd(input string nm, input logic [31:0] a, input logic [31:0] exp);
		apb(1'b0, a, 32'h0);
		check(nm, rdv, exp);
	endtask : rd

	// Sampled on the falling edge so one-cycle pulses are seen settled
	task automatic wait_for(input logic use_dma);
		int n;
		n = 0;
		@(negedge pclk);
		while ((use_dma ? dma_request : ready_irq) !== 1'b1 && n < 3000) begin
			@(negedge pclk);
			n++;
		end
		if (n >= 3000) begin
			mismatches++;
			$display("CHECK FAILED completion expected 1 seen 0");
		end
	endtask : wait_for

	initial begin
		presetn = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 32'h0;
		pwdata = 32'h0;
		resp = 10'h2AB;
		mismatches = 0;
		checks_done = 0;
		cycles = 0;
		go_cnt = 0;
		close_cnt = 0;
		repeat (8) @(posedge pclk);
		presetn <= 1'b1;
		@(negedge pclk);
		check("reset cm", 32'(shifter_common_mode), 32'h1);
		check("reset ofs trim", 32'({pos_offset, neg_offset, trim_value}), 32'h0401_0038);
		for (int i = 0; i < 9; i++) begin
			rd($sformatf("reset reg %0d", i), ra[i], re[i]);
		end
		apb(1'b0, 32'h48, 32'h0);
		check("unmapped err", 32'(errv), 32'h1);
		$display("test reset done");
		apb(1'b1, A_MAIN, 32'h1FC0);
		rd("main fields", A_MAIN, 32'h17C0);
		check("mode outs", 32'({single_ended_sel, input_mute, chopper_on, regulator_hold,
			die_temp_on}), 32'h1F);
		check("sign out", 32'(polarity_invert), 32'h1);
		apb(1'b1, A_TIM, 32'h0027);
		@(negedge pclk);
		check("timing outs", 32'({shifter_on, shifter_common_mode, load_current_on,
			attenuator_sel}), 32'h17);
		apb(1'b1, A_TIM, 32'h0008);
		@(negedge pclk);
		check("shifter out", 32'(shifter_on), 32'h1);
		apb(1'b1, A_SEL, 32'h00FF);
		rd("select", A_SEL, 32'h0077);
		check("select outs", 32'({input_pos_sel, input_neg_sel}), 32'h3F);
		$display("test fields done");
		apb(1'b1, A_MAIN, 32'h0000);
		apb(1'b1, A_TIM, 32'h0000);
		apb(1'b1, A_INT, 32'h0001);
		apb(1'b1, A_MAIN, 32'h0001);
		@(negedge pclk);
		check("power order", 32'({regulator_on, converter_enable}), 32'h2);
		repeat (10) @(negedge pclk);
		check("conv enable", 32'(converter_enable), 32'h1);
		$display("test power done");
		apb(1'b1, A_MAIN, 32'h0023);
		wait_for(1'b0);
		rd("single main", A_MAIN, 32'h0031);
		rd("single result", A_RES, 32'hAAC0);
		apb(1'b1, A_MAIN, 32'h0001);
		@(negedge pclk);
		check("masked irq", 32'(ready_irq), 32'h0);
		apb(1'b1, A_MAIN, 32'h0021);
		@(negedge pclk);
		check("unmasked irq", 32'(ready_irq), 32'h1);
		apb(1'b1, A_CLR, 32'h0000);
		repeat (30) @(negedge pclk);
		rd("flag cleared", A_MAIN, 32'h0021);
		rd("clear reads 0", A_CLR, 32'h0000);
		$display("test single done");
		resp = 10'h100;
		apb(1'b1, A_TIM, 32'h0200);
		go_cnt = 0;
		close_cnt = 0;
		apb(1'b1, A_MAIN, 32'h0223);
		wait_for(1'b0);
		check("chop samples", 32'(go_cnt), 32'h2);
		check("chop close", 32'(close_cnt), 32'h10);
		check("chop sign", 32'(pol_log[1] ^ pol_log[0]), 32'h1);
		rd("chop result", A_RES, 32'h4000);
		apb(1'b1, A_CLR, 32'h0001);
		$display("test chop done");
		resp = 10'h3FF;
		apb(1'b1, A_MAIN, 32'h0001);
		apb(1'b1, A_INT, 32'h1001);
		apb(1'b1, A_MAIN, 32'h002F);
		wait_for(1'b1);
		resp = 10'h001;
		rd("cont result 1", A_RES, 32'hFFC0);
		rd("cont busy", A_MAIN, 32'h003F);
		apb(1'b1, A_CLR, 32'h0000);
		wait_for(1'b1);
		rd("cont result 2", A_RES, 32'h0040);
		apb(1'b1, A_MAIN, 32'h0029);
		repeat (100) @(negedge pclk);
		rd("cont stopped", A_MAIN, 32'h0039);
		apb(1'b1, A_RES, 32'hFFFF);
		rd("result kept", A_RES, 32'h0040);
		$display("test continuous done");
		apb(1'b1, A_MAIN, 32'h0000);
		@(negedge pclk);
		check("power off", 32'({regulator_on, converter_enable}), 32'h0);
		$display("test power off done");
		wrap_up();
	end
endmodule : asc_sequencer_tb
`default_nettype wire
